// ---- lcdms_pkg.sv ----
// constants shared by the lcd multiplex drive selector
package lcdms_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_SEG = 40;
  localparam int unsigned NUM_BP = 4;
  localparam int unsigned ROW_BYTES = 5;
  localparam int unsigned RAM_DEPTH = 20;
  localparam int unsigned RAM_AW = 5;
  localparam int unsigned LVL_W = 3;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PHASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RAM_BASE = 8'h40;
  localparam logic [7:0] REG_RAM_END = 8'h90;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_BIAS_BIT = 3;
  localparam int unsigned CTRL_INV_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h06;
  // ---------------------------------------------------------------
  // drive modes, bias, inversion
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_MUX2 = 2'h1;
  localparam logic [1:0] MODE_MUX3 = 2'h2;
  localparam logic [1:0] MODE_MUX4 = 2'h3;
  localparam logic BIAS_THIRD = 1'b0;
  localparam logic BIAS_HALF = 1'b1;
  localparam logic INV_LINE = 1'b0;
  localparam logic INV_FRAME = 1'b1;
  // ---------------------------------------------------------------
  // level-select codes toward the analog switches
  // ---------------------------------------------------------------
  localparam logic [2:0] LVL_VSS = 3'h0;
  localparam logic [2:0] LVL_THIRD = 3'h1;
  localparam logic [2:0] LVL_HALF = 3'h2;
  localparam logic [2:0] LVL_TWO_THIRDS = 3'h3;
  localparam logic [2:0] LVL_FULL = 3'h4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHASE_TIME_NS = 10000;
  localparam logic [15:0] PHASE_LEN_RST = 16'(PHASE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PHASE_LEN_MIN = 16'h0008;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ---------------------------------------------------------------
  // bus slave states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD_MEM, BUS_RD_OUT} lcdms_bus_e;
endpackage

// ---- lcdms_ram.sv ----
// display data memory, one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none
module lcdms_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 20,
  parameter int unsigned AW = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port a
  input wire logic [AW-1:0] a_addr,
  output logic [WIDTH-1:0] a_data,
  // read port b
  input wire logic [AW-1:0] b_addr,
  output logic [WIDTH-1:0] b_data
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  // cleared on reset so every element starts off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      a_data <= '0;
      b_data <= '0;
    end else begin
      if (wr_en && (int'(wr_addr) < DEPTH)) begin
        mem_ff[wr_addr] <= wr_data;
      end
      a_data <= (int'(a_addr) < DEPTH) ? mem_ff[a_addr] : '0;
      b_data <= (int'(b_addr) < DEPTH) ? mem_ff[b_addr] : '0;
    end
  end
endmodule
`default_nettype wire

// ---- lcdms_drive.sv ----
// lcd backplane and segment level selector with ahb-lite registers
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module lcdms_drive
  import lcdms_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // level codes toward the analog switches
  output logic [LVL_W-1:0] backplane_out_0,
  output logic [LVL_W-1:0] backplane_out_1,
  output logic [LVL_W-1:0] backplane_out_2,
  output logic [LVL_W-1:0] backplane_out_3,
  output logic [NUM_SEG*LVL_W-1:0] segment_outs
);
  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  lcdms_bus_e bus_st_ff, nxt_bus_st;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic map_ff, nxt_map;
  logic hreadyout_ff, nxt_hreadyout;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [4:0] ctrl_ff, nxt_ctrl;
  logic [15:0] phase_ff, nxt_phase;
  logic acc, ram_hit, ram_we;
  logic [RAM_AW-1:0] ram_idx;
  logic [7:0] ram_a_data, ram_b_data;
  logic [RAM_AW-1:0] scan_addr;
  logic [31:0] status_word;

  assign acc = hsel && hready && htrans[1];
  assign ram_hit = map_ff && (addr_ff[1:0] == 2'h0) &&
                   (addr_ff >= REG_RAM_BASE) && (addr_ff < REG_RAM_END);
  assign ram_idx = RAM_AW'((addr_ff - REG_RAM_BASE) >> 2);
  assign ram_we = wr_pend_ff && ram_hit;

  always_comb begin
    nxt_bus_st = bus_st_ff;
    nxt_wr_pend = 1'b0;
    nxt_addr = addr_ff;
    nxt_map = map_ff;
    nxt_hreadyout = hreadyout_ff;
    nxt_hrdata = hrdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_phase = phase_ff;
    if (wr_pend_ff && map_ff) begin
      if (addr_ff == REG_CTRL) begin
        nxt_ctrl = hwdata[4:0];
      end else if (addr_ff == REG_PHASE) begin
        nxt_phase = (hwdata[15:0] < PHASE_LEN_MIN) ? PHASE_LEN_MIN :
                    hwdata[15:0];
      end
    end
    case (bus_st_ff)
      BUS_IDLE: begin
        if (acc) begin
          nxt_addr = haddr[7:0];
          nxt_map = (haddr[31:8] == 24'h000000);
          nxt_wr_pend = hwrite;
          if (!hwrite) begin
            nxt_bus_st = BUS_RD_MEM;
            nxt_hreadyout = 1'b0;
          end
        end
      end
      BUS_RD_MEM: begin
        nxt_bus_st = BUS_RD_OUT;
      end
      BUS_RD_OUT: begin
        nxt_bus_st = BUS_IDLE;
        nxt_hreadyout = 1'b1;
        nxt_hrdata = 32'h00000000;
        if (ram_hit) begin
          nxt_hrdata = {24'h000000, ram_a_data};
        end else if (map_ff && addr_ff == REG_CTRL) begin
          nxt_hrdata = {27'h0000000, ctrl_ff};
        end else if (map_ff && addr_ff == REG_PHASE) begin
          nxt_hrdata = {16'h0000, phase_ff};
        end else if (map_ff && addr_ff == REG_STATUS) begin
          nxt_hrdata = status_word;
        end
      end
      default: begin
        nxt_bus_st = BUS_IDLE;
        nxt_hreadyout = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_ff <= BUS_IDLE;
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      map_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
      ctrl_ff <= CTRL_RST;
      phase_ff <= PHASE_LEN_RST;
      hresp <= 1'b0;
    end else begin
      bus_st_ff <= nxt_bus_st;
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      map_ff <= nxt_map;
      hreadyout_ff <= nxt_hreadyout;
      hrdata_ff <= nxt_hrdata;
      ctrl_ff <= nxt_ctrl;
      phase_ff <= nxt_phase;
      hresp <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;

  lcdms_ram #(
    .WIDTH(8),
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW)
  ) u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(ram_we),
    .wr_addr(ram_idx),
    .wr_data(hwdata[7:0]),
    .a_addr(ram_idx),
    .a_data(ram_a_data),
    .b_addr(scan_addr),
    .b_data(ram_b_data)
  );

  // ---------------------------------------------------------------
  // multiplex sequencer
  // ---------------------------------------------------------------
  logic [15:0] cnt_ff, nxt_cnt;
  logic [1:0] row_ff, nxt_row, nrow_ff, nxt_nrow;
  logic pol_ff, nxt_pol, npol_ff, nxt_npol;
  logic half_ff, nxt_half, nhalf_ff, nxt_nhalf;
  logic [1:0] pmode_ff, nxt_pmode, omode_ff, nxt_omode;
  logic pbias_ff, nxt_pbias, obias_ff, nxt_obias;
  logic pen_ff, nxt_pen;
  logic [NUM_SEG-1:0] stage_ff, nxt_stage;
  logic bound, wrap;
  logic [1:0] cmode, adv, keep;

  assign bound = (cnt_ff >= phase_ff - 16'h0001);
  assign cmode = ctrl_ff[CTRL_MODE_LSB +: 2];
  assign wrap = (row_ff >= cmode);
  assign adv = wrap ? 2'h0 : row_ff + 2'h1;
  assign keep = (row_ff > cmode) ? 2'h0 : row_ff;
  // next row's five bytes are fetched on counts 1..5
  assign scan_addr = RAM_AW'({nrow_ff, 2'b00}) + RAM_AW'(nrow_ff) +
                     RAM_AW'(cnt_ff[2:0]) - 5'h01;
  assign status_word = {27'h0000000, ctrl_ff[CTRL_EN_BIT], half_ff,
                        pol_ff, row_ff};

  always_comb begin
    nxt_cnt = bound ? 16'h0000 : cnt_ff + 16'h0001;
    nxt_nrow = nrow_ff;
    nxt_npol = npol_ff;
    nxt_nhalf = nhalf_ff;
    nxt_pmode = pmode_ff;
    nxt_pbias = pbias_ff;
    nxt_pen = pen_ff;
    nxt_stage = stage_ff;
    nxt_row = row_ff;
    nxt_pol = pol_ff;
    nxt_half = half_ff;
    nxt_omode = omode_ff;
    nxt_obias = obias_ff;
    if (cnt_ff == 16'h0000) begin
      nxt_pmode = cmode;
      nxt_pbias = ctrl_ff[CTRL_BIAS_BIT];
      nxt_pen = ctrl_ff[CTRL_EN_BIT];
      if (ctrl_ff[CTRL_INV_BIT] == INV_LINE) begin
        nxt_nrow = half_ff ? adv : keep;
        nxt_npol = ~pol_ff;
        nxt_nhalf = ~half_ff;
      end else begin
        nxt_nrow = adv;
        nxt_npol = wrap ? ~pol_ff : pol_ff;
        nxt_nhalf = 1'b0;
      end
    end
    for (int k = 0; k < ROW_BYTES; k++) begin
      if (cnt_ff == 16'(k + 2)) begin
        nxt_stage[8*k +: 8] = ram_b_data;
      end
    end
    if (bound) begin
      nxt_row = nrow_ff;
      nxt_pol = npol_ff;
      nxt_half = nhalf_ff;
      nxt_omode = pmode_ff;
      nxt_obias = pbias_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 16'h0000;
      row_ff <= 2'h0;
      pol_ff <= 1'b0;
      half_ff <= 1'b0;
      nrow_ff <= 2'h0;
      npol_ff <= 1'b0;
      nhalf_ff <= 1'b0;
      pmode_ff <= MODE_MUX4;
      pbias_ff <= BIAS_THIRD;
      pen_ff <= 1'b0;
      omode_ff <= MODE_MUX4;
      obias_ff <= BIAS_THIRD;
      stage_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      row_ff <= nxt_row;
      pol_ff <= nxt_pol;
      half_ff <= nxt_half;
      nrow_ff <= nxt_nrow;
      npol_ff <= nxt_npol;
      nhalf_ff <= nxt_nhalf;
      pmode_ff <= nxt_pmode;
      pbias_ff <= nxt_pbias;
      pen_ff <= nxt_pen;
      omode_ff <= nxt_omode;
      obias_ff <= nxt_obias;
      stage_ff <= nxt_stage;
    end
  end

  // ---------------------------------------------------------------
  // level selection
  // ---------------------------------------------------------------
  // logical backplane that a physical output repeats
  function automatic logic [1:0] bp_row(input logic [1:0] m,
                                        input logic [1:0] i);
    logic [1:0] r;
    r = i;
    case (m)
      MODE_STATIC: r = 2'h0;
      MODE_MUX2: r = {1'b0, i[0]};
      MODE_MUX3: r = (i == 2'h3) ? 2'h1 : i;
      default: r = i;
    endcase
    return r;
  endfunction

  logic two_lvl;
  logic [LVL_W-1:0] bp_lvl [NUM_BP];
  logic [LVL_W-1:0] bp_ff [NUM_BP];
  logic [NUM_SEG*LVL_W-1:0] seg_lvl, seg_ff;

  // static drive or half bias never uses the third taps
  assign two_lvl = (pmode_ff == MODE_STATIC) || (pbias_ff == BIAS_HALF);

  for (genvar b = 0; b < NUM_BP; b++) begin : g_bp
    always_comb begin
      if (!pen_ff) begin
        bp_lvl[b] = LVL_VSS;
      end else if (bp_row(pmode_ff, 2'(b)) == nrow_ff) begin
        bp_lvl[b] = npol_ff ? LVL_FULL : LVL_VSS;
      end else if (pbias_ff == BIAS_HALF) begin
        bp_lvl[b] = LVL_HALF;
      end else begin
        bp_lvl[b] = npol_ff ? LVL_THIRD : LVL_TWO_THIRDS;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        bp_ff[b] <= LVL_VSS;
      end else begin
        bp_ff[b] <= bound ? bp_lvl[b] : bp_ff[b];
      end
    end
  end

  for (genvar j = 0; j < NUM_SEG; j++) begin : g_seg
    always_comb begin
      if (!pen_ff) begin
        seg_lvl[j*LVL_W +: LVL_W] = LVL_VSS;
      end else if (stage_ff[j]) begin
        seg_lvl[j*LVL_W +: LVL_W] = npol_ff ? LVL_VSS : LVL_FULL;
      end else if (two_lvl) begin
        seg_lvl[j*LVL_W +: LVL_W] = npol_ff ? LVL_FULL : LVL_VSS;
      end else begin
        seg_lvl[j*LVL_W +: LVL_W] = npol_ff ? LVL_TWO_THIRDS :
                                    LVL_THIRD;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_ff <= '0;
    end else begin
      seg_ff <= bound ? seg_lvl : seg_ff;
    end
  end

  assign backplane_out_0 = bp_ff[0];
  assign backplane_out_1 = bp_ff[1];
  assign backplane_out_2 = bp_ff[2];
  assign backplane_out_3 = bp_ff[3];
  assign segment_outs = seg_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ctrl_wr;
    wr_pend_ff && map_ff && addr_ff == REG_CTRL;
  endsequence
  sequence s_phase_end;
    bound && pen_ff;
  endsequence

  a_bp3_mux3: assert property (omode_ff == MODE_MUX3 |->
    backplane_out_3 == backplane_out_1) else $error("bp3 differs from bp1");
  a_pairs_mux2: assert property (omode_ff == MODE_MUX2 |->
    backplane_out_0 == backplane_out_2 && backplane_out_1 == backplane_out_3)
    else $error("mux2 pairs differ");
  a_static_same: assert property (omode_ff == MODE_STATIC |->
    backplane_out_0 == backplane_out_1 && backplane_out_2 == backplane_out_3
    && backplane_out_0 == backplane_out_2
    && (backplane_out_0 == LVL_VSS || backplane_out_0 == LVL_FULL))
    else $error("static backplanes differ");
  a_half_taps: assert property (obias_ff == BIAS_HALF |->
    backplane_out_0 != LVL_THIRD && backplane_out_0 != LVL_TWO_THIRDS &&
    segment_outs[2:0] != LVL_THIRD) else $error("third tap in half bias");
  a_ctrl_write: assert property (s_ctrl_wr |=>
    ctrl_ff == $past(hwdata[4:0])) else $error("control not written");
  a_hold_phase: assert property (!$past(bound) |->
    $stable(segment_outs) && $stable(backplane_out_2))
    else $error("level changed mid phase");
  a_seg_on: assert property ((s_phase_end and stage_ff[0]) |=>
    segment_outs[2:0] == ($past(npol_ff) ? LVL_VSS : LVL_FULL))
    else $error("on segment level wrong");
  a_one_active: assert property ((s_phase_end and
    pmode_ff == MODE_MUX4) |=> (backplane_out_0 == LVL_FULL ||
    backplane_out_0 == LVL_VSS) == (row_ff == 2'h0))
    else $error("active backplane wrong");
  a_frame_pol: assert property (cnt_ff == 16'h0000 &&
    ctrl_ff[CTRL_INV_BIT] == INV_FRAME && !wrap |=> npol_ff == $past(pol_ff))
    else $error("frame polarity flipped early");
  a_rd_wait: assert property (acc && !hwrite && bus_st_ff == BUS_IDLE |=>
    !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read timing");
endmodule
`default_nettype wire

// ---- lcdms_glass.sv ----
// lcd glass model: finds the driven backplane, its polarity, lit segments
`timescale 1ns/100ps
`default_nettype none
module lcdms_glass
  import lcdms_pkg::*;
(
  // level codes from the driver
  input wire logic [LVL_W-1:0] backplane_out_0,
  input wire logic [LVL_W-1:0] backplane_out_1,
  input wire logic [LVL_W-1:0] backplane_out_2,
  input wire logic [LVL_W-1:0] backplane_out_3,
  input wire logic [NUM_SEG*LVL_W-1:0] segment_outs,
  // decoded phase and element state
  output logic [1:0] row,
  output logic pol,
  output logic [NUM_SEG-1:0] lit
);
  logic [LVL_W-1:0] bp [NUM_BP];
  logic [LVL_W-1:0] on_lvl;

  assign bp[0] = backplane_out_0;
  assign bp[1] = backplane_out_1;
  assign bp[2] = backplane_out_2;
  assign bp[3] = backplane_out_3;

  // lowest backplane at a rail level is the one being scanned
  always_comb begin
    row = 2'h0;
    pol = 1'b0;
    for (int k = NUM_BP - 1; k >= 0; k--) begin
      if (bp[k] === LVL_FULL || bp[k] === LVL_VSS) begin
        row = 2'(k);
        pol = (bp[k] === LVL_FULL);
      end
    end
    on_lvl = pol ? LVL_VSS : LVL_FULL;
    for (int j = 0; j < NUM_SEG; j++) begin
      lit[j] = (segment_outs[j*LVL_W +: LVL_W] === on_lvl);
    end
  end
endmodule
`default_nettype wire

// ---- lcdms_drive_tb.sv ----
// self-checking bench for the lcd level selector
`timescale 1ns/100ps
`default_nettype none
module lcdms_drive_tb;
  import lcdms_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int VW = (NUM_SEG + NUM_BP) * LVL_W;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, g_pol;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, g_row;
  logic [2:0] hsize;
  logic [LVL_W-1:0] bp0, bp1, bp2, bp3;
  logic [NUM_SEG*LVL_W-1:0] segs;
  logic [NUM_SEG-1:0] g_lit;
  logic [7:0] mem [RAM_DEPTH];
  int err_total, tests_run;
  wire logic [VW-1:0] outs = {segs, bp3, bp2, bp1, bp0};

  lcdms_drive DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .backplane_out_0(bp0),
    .backplane_out_1(bp1), .backplane_out_2(bp2), .backplane_out_3(bp3),
    .segment_outs(segs));

  lcdms_glass glass (.backplane_out_0(bp0), .backplane_out_1(bp1),
    .backplane_out_2(bp2), .backplane_out_3(bp3), .segment_outs(segs),
    .row(g_row), .pol(g_pol), .lit(g_lit));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    #200us;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // checks and bus cycles
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic chk_lvl(input logic [VW-1:0] got, input logic [VW-1:0] exp,
                         input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s levels %h want %h", $time, what,
               got, exp);
    end
  endtask

  task automatic wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  // called just after a rising edge; read data holds until the next read
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  // ---------------------------------------------------------------
  // expected levels
  // ---------------------------------------------------------------
  function automatic logic [LVL_W-1:0] bp_lvl(input logic [1:0] m,
      input logic b, input int k, input int r, input logic p);
    int e;
    e = (m == MODE_MUX2) ? k % 2 : (m == MODE_MUX3 && k == 3) ? 1 : k;
    if (m == MODE_STATIC || e == r) return p ? LVL_FULL : LVL_VSS;
    if (b == BIAS_HALF) return LVL_HALF;
    return p ? LVL_THIRD : LVL_TWO_THIRDS;
  endfunction

  function automatic logic [VW-1:0] exp_vec(input logic [4:0] c,
      input int r, input logic p);
    logic [VW-1:0] v;
    logic [1:0] m;
    logic lo;
    v = '0;
    m = c[CTRL_MODE_LSB +: 2];
    if (!c[CTRL_EN_BIT]) return v;
    lo = (m == MODE_STATIC) || (c[CTRL_BIAS_BIT] == BIAS_HALF);
    for (int k = 0; k < NUM_BP; k++) begin
      v[k*LVL_W +: LVL_W] = bp_lvl(m, c[CTRL_BIAS_BIT], k, r, p);
    end
    for (int j = 0; j < NUM_SEG; j++) begin
      v[(NUM_BP+j)*LVL_W +: LVL_W] = mem[ROW_BYTES*r + j/8][j%8] ?
        (p ? LVL_VSS : LVL_FULL) : lo ? (p ? LVL_FULL : LVL_VSS) :
        (p ? LVL_TWO_THIRDS : LVL_THIRD);
    end
    return v;
  endfunction

  task automatic next_phase(output int dt);
    logic [2:0] s;
    s = {g_row, g_pol};
    dt = 0;
    do begin
      @(negedge hclk);
      dt++;
    end while ({g_row, g_pol} === s && dt < 40);
  endtask

  task automatic run_cfg(input logic [4:0] c);
    int dt, r, nr, nb;
    logic p, np, stay, first;
    logic [VW-1:0] e, el;
    nb = int'(c[CTRL_MODE_LSB +: 2]) + 1;
    bus(1'b1, 32'(REG_CTRL), 32'(c), rd);
    repeat (3) next_phase(dt);
    r = g_row;
    p = g_pol;
    first = 1'b1;
    stay = 1'b0;
    repeat (12) begin
      next_phase(dt);
      chk_word(32'(dt), 32'(PHASE_LEN_MIN), "phase length");
      e = exp_vec(c, g_row, g_pol);
      el = '0;
      for (int j = 0; j < NUM_SEG; j++) begin
        el[j] = mem[ROW_BYTES*g_row + j/8][j%8];
      end
      chk_lvl(VW'(outs[11:0]), VW'(e[11:0]), "bp");
      chk_lvl(outs, e, "all");
      chk_lvl(VW'(g_lit), el, "lit");
      if (c[CTRL_INV_BIT] == INV_FRAME) begin
        nr = (r + 1) % nb;
        np = (nr == 0) ? !p : p;
      end else begin
        np = !p;
        nr = first ? int'(g_row) : stay ? (r + 1) % nb : r;
      end
      chk_word(32'({g_row, g_pol}), 32'({2'(nr), np}), "order");
      stay = (int'(g_row) == r);
      r = g_row;
      p = g_pol;
      first = 1'b0;
    end
    @(posedge hclk);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(85));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_lvl(outs, '0, "reset");
    bus(1'b0, 32'(REG_CTRL), '0, rd);
    chk_word(rd, 32'(CTRL_RST), "ctrl reset");
    chk_word(32'(hresp), 32'h0, "response");
    bus(1'b0, 32'(REG_PHASE), '0, rd);
    chk_word(rd, 32'(PHASE_LEN_RST), "phase reset");
    bus(1'b1, 32'h0000_0300, 32'hffff_ffff, rd);
    bus(1'b0, 32'h0000_0300, '0, rd);
    chk_word(rd, 32'h0, "unmapped");
    bus(1'b0, 32'(REG_CTRL), '0, rd);
    chk_word(rd, 32'(CTRL_RST), "ctrl kept");
    bus(1'b1, 32'(REG_PHASE), 32'h3, rd);
    bus(1'b0, 32'(REG_PHASE), '0, rd);
    chk_word(rd, 32'(PHASE_LEN_MIN), "phase floor");
    for (i = 0; i < RAM_DEPTH; i++) begin
      mem[i] = (i == 0) ? 8'h00 : (i == RAM_DEPTH - 1) ? 8'hff : 8'($urandom);
      bus(1'b1, 32'(REG_RAM_BASE) + 4*i, {24'($urandom), mem[i]}, rd);
    end
    bus(1'b0, 32'(REG_RAM_BASE) + 4*7, '0, rd);
    chk_word(rd, {24'h0, mem[7]}, "ram read");
    for (i = 0; i < 16; i++) begin
      run_cfg(5'({4'(i), 1'b1}));
      mem[i] = 8'($urandom);
      bus(1'b1, 32'(REG_RAM_BASE) + 4*i, 32'(mem[i]), rd);
    end
    bus(1'b1, 32'(REG_CTRL), 32'(CTRL_RST), rd);
    repeat (3 * PHASE_LEN_MIN) @(posedge hclk);
    chk_lvl(outs, '0, "disabled");
    tally_and_finish();
  end
endmodule
`default_nettype wire
